// ---- bms_seq_top.sv ----
// backlight functional state sequencer and fault supervisor
`timescale 1ns/10ps
`include "bms_defs.svh"
module bms_seq_top #(
  parameter int unsigned SOFT_CYC  = `BMS_SOFT_CYC,
  parameter int unsigned RAMP_CYC  = `BMS_RAMP_CYC,
  parameter int unsigned RECOV_CYC = `BMS_RECOV_CYC,
  parameter int unsigned DISCH_CYC = `BMS_DISCH_CYC,
  parameter int unsigned BUSTO_CYC = `BMS_BUSTO_CYC,
  parameter int unsigned SHORT_CYC = `BMS_SHORT_CYC
)(
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire logic                   en_pin,
  input  wire logic                   brightness_nz,
  input  wire logic                   ldo_ready,
  input  wire logic                   nvm_loaded,
  input  wire logic                   detect_done,
  input  wire logic                   current_set_pin_low,
  input  wire logic                   thermal_hot,
  input  wire logic                   boost_at_max,
  input  wire bms_pkg::bms_chmask_t   string_used,
  input  wire bms_pkg::bms_chmask_t   headroom_low,
  input  wire bms_pkg::bms_chmask_t   headroom_high,
  input  wire bms_pkg::bms_chmask_t   gnd_low,
  input  wire bms_pkg::bms_chmask_t   unused_not_gnd,
  input  wire logic                   bus_busy,
  input  wire logic [11:0]            drive_current_cfg,
  input  wire logic                   clr_wr,
  input  wire bms_pkg::bms_flt_t      clr_status,
  input  wire bms_pkg::bms_flt_t      clr_bits,
  input  wire logic                   ien_wr,
  input  wire logic [2*`BMS_NFLT-1:0] ien_wdata,
  output logic [2*`BMS_NFLT-1:0]      ien_rdata,
  output logic                        ldo_en,
  output logic                        nvm_load_req,
  output logic                        detect_req,
  output logic                        plsw_en,
  output logic                        plsw_soft,
  output logic                        boost_en,
  output logic                        boost_ilim_low,
  output logic                        boost_flt_en,
  output logic                        vin_flt_en,
  output logic                        gnd_test_en,
  output logic                        string_flt_en,
  output bms_pkg::bms_chmask_t        driver_en,
  output bms_pkg::bms_chmask_t        string_off,
  output logic                        discharge_en,
  output logic                        power_off,
  output logic                        cfg_write_ok,
  output logic                        alert_n,
  output logic                        bus_reset,
  output logic [11:0]                 drive_current_code,
  output bms_pkg::bms_flt_t           fault_flags,
  output logic [3:0]                  state_code
);
  import bms_pkg::*;

  bms_state_e            state_reg;
  bms_state_e            state_next;
  logic [`BMS_TMR_W-1:0] tmr_reg;
  logic [`BMS_TMR_W-1:0] bus_tmr_reg;
  bms_flt_t              flags_reg;
  bms_flt_t              flags_next;
  bms_flt_t              ien_reg;
  bms_flt_t              evt;
  bms_chmask_t           string_off_reg;
  bms_chmask_t           gnd_scan;
  logic                  tmr_done;
  logic                  gnd_hit;
  logic                  bus_to_hit;
  logic                  all_off;
  logic                  running;
  bms_str_if             sif ();

  // true when state timer reached the given count minus one
  function automatic logic tmr_at(input logic [`BMS_TMR_W-1:0] t,
                                  input int unsigned cyc);
    tmr_at = (t >= `BMS_TMR_W'(cyc - 1));
  endfunction

  // states where the power path is up
  function automatic logic is_run(input bms_state_e s);
    is_run = (s == BMS_SOFT) || (s == BMS_RAMP) || (s == BMS_NORMAL);
  endfunction

  // string monitor hookup
  assign sif.monitor_en    = string_flt_en;
  assign sif.boost_at_max  = boost_at_max;
  assign sif.active        = string_used & ~string_off_reg;
  assign sif.headroom_low  = headroom_low;
  assign sif.headroom_high = headroom_high;

  bms_str_mon #(
    .SHORT_CYC (SHORT_CYC)
  ) u_str_mon (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .sif     (sif)
  );

  // fault conditions seen this cycle
  assign running  = is_run(state_reg);
  assign gnd_scan = (state_reg == BMS_SOFT) ? string_used
                  : (string_used & ~driver_en);
  assign gnd_hit  = gnd_test_en
                    && |(gnd_low & gnd_scan & ~string_off_reg);
  assign all_off  = (string_used != '0)
                    && ((string_used & ~string_off_reg) == '0);
  assign tmr_done = (state_reg == BMS_SOFT)  ? tmr_at(tmr_reg, SOFT_CYC)
                  : (state_reg == BMS_RAMP)  ? tmr_at(tmr_reg, RAMP_CYC)
                  : (state_reg == BMS_RECOV) ? tmr_at(tmr_reg, RECOV_CYC)
                  : (state_reg == BMS_SHUT)  ? tmr_at(tmr_reg, DISCH_CYC)
                  : 1'b0;
  assign bus_to_hit = bus_busy
                      && bus_tmr_reg == `BMS_TMR_W'(BUSTO_CYC - 1);

  // next state
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      BMS_INIT:
        if (detect_done && ldo_ready && nvm_loaded)
          state_next = BMS_STANDBY;
      BMS_STANDBY:
        if (!thermal_hot)
          state_next = BMS_SOFT;
      BMS_SOFT:
        if (gnd_hit)
          state_next = BMS_RECOV;
        else if (tmr_done)
          state_next = BMS_RAMP;
      BMS_RAMP:
        if (gnd_hit)
          state_next = BMS_RECOV;
        else if (tmr_done)
          state_next = BMS_NORMAL;
      BMS_NORMAL:
        if (all_off)
          state_next = BMS_LATCH;
        else if (gnd_hit)
          state_next = BMS_RECOV;
      BMS_RECOV:
        if (tmr_done && brightness_nz)
          state_next = BMS_STANDBY;
      BMS_LATCH:
        state_next = BMS_LATCH;
      BMS_SHUT:
        if (tmr_done)
          state_next = BMS_OFF;
      BMS_OFF:
        if (en_pin)
          state_next = BMS_INIT;
      default:
        state_next = BMS_INIT;
    endcase
    if (running && thermal_hot)
      state_next = BMS_STANDBY;
    if (!en_pin && state_reg != BMS_SHUT && state_reg != BMS_OFF)
      state_next = BMS_SHUT;
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= BMS_INIT;
    else
      state_reg <= state_next;
  end

  // state timer, restarted on each state change
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      tmr_reg <= '0;
    else if (state_next != state_reg)
      tmr_reg <= '0;
    else if (!tmr_done)
      tmr_reg <= tmr_reg + `BMS_TMR_W'(1);
  end

  // bus stall timer
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      bus_tmr_reg <= '0;
    else if (!bus_busy || bus_to_hit)
      bus_tmr_reg <= '0;
    else
      bus_tmr_reg <= bus_tmr_reg + `BMS_TMR_W'(1);
  end

  // serial logic reset pulse
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      bus_reset <= 1'b0;
    else
      bus_reset <= bus_to_hit;
  end

  // fault events
  always_comb
  begin
    evt                = '0;
    evt[`BMS_F_CURRENT_SET_PIN]   = current_set_pin_low;
    evt[`BMS_F_TSD]    = running && thermal_hot;
    evt[`BMS_F_OPEN]   = |sif.open_hit;
    evt[`BMS_F_SHORT]  = |sif.short_hit;
    evt[`BMS_F_GND]    = gnd_hit;
    evt[`BMS_F_INV]    = cfg_write_ok && |(unused_not_gnd & ~string_used);
    evt[`BMS_F_BUS]    = bus_to_hit;
  end

  // sticky flags, set wins over clear
  assign flags_next = evt | (flags_reg
                    & ~({`BMS_NFLT{clr_wr}} & clr_status & clr_bits));

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      flags_reg <= '0;
    else
      flags_reg <= flags_next;
  end
  assign fault_flags = flags_reg;

  // alert enable pairs, all enabled after reset
  genvar fi;
  generate
    for (fi = 0; fi < `BMS_NFLT; fi = fi + 1)
    begin : g_ien
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
          ien_reg[fi] <= 1'b1;
        else if (ien_wr && ien_wdata[2*fi+:2] == `BMS_IEN_WR_ON)
          ien_reg[fi] <= 1'b1;
        else if (ien_wr && ien_wdata[2*fi+:2] == `BMS_IEN_WR_OFF)
          ien_reg[fi] <= 1'b0;
      end
      assign ien_rdata[2*fi+:2] = ien_reg[fi] ? `BMS_IEN_RD_ON
                                              : `BMS_IEN_RD_OFF;
    end
  endgenerate

  // alert pin, low while an enabled flag stands
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      alert_n <= 1'b1;
    else
      alert_n <= ~|(flags_next & ien_reg);
  end

  // disabled strings, re-enabled on power cycle
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      string_off_reg <= '0;
    else if (state_reg == BMS_INIT)
      string_off_reg <= '0;
    else
      string_off_reg <= string_off_reg | sif.open_hit
                        | sif.short_hit;
  end
  assign string_off = string_off_reg;

  // drive current code, forced while the pin fault stands
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      drive_current_code <= `BMS_CURRENT_SET_PIN_CODE;
    else if (flags_next[`BMS_F_CURRENT_SET_PIN])
      drive_current_code <= `BMS_CURRENT_SET_PIN_CODE;
    else
      drive_current_code <= drive_current_cfg;
  end

  // power path and detection enables from the next state
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ldo_en         <= 1'b0;
      nvm_load_req   <= 1'b0;
      detect_req     <= 1'b0;
      plsw_en        <= 1'b0;
      plsw_soft      <= 1'b0;
      boost_en       <= 1'b0;
      boost_ilim_low <= 1'b0;
      boost_flt_en   <= 1'b0;
      vin_flt_en     <= 1'b0;
      gnd_test_en    <= 1'b0;
      string_flt_en  <= 1'b0;
      discharge_en   <= 1'b0;
      power_off      <= 1'b0;
      cfg_write_ok   <= 1'b0;
      state_code     <= 4'h0;
    end
    else
    begin
      ldo_en         <= state_next != BMS_OFF;
      nvm_load_req   <= state_next == BMS_INIT && ldo_ready;
      detect_req     <= state_next == BMS_INIT && ldo_ready && nvm_loaded;
      plsw_en        <= is_run(state_next);
      plsw_soft      <= state_next == BMS_SOFT;
      boost_en       <= state_next == BMS_RAMP
                        || state_next == BMS_NORMAL;
      boost_ilim_low <= state_next == BMS_RAMP;
      boost_flt_en   <= state_next == BMS_NORMAL;
      vin_flt_en     <= is_run(state_next);
      gnd_test_en    <= is_run(state_next);
      string_flt_en  <= state_next == BMS_NORMAL;
      discharge_en   <= state_next == BMS_SHUT;
      power_off      <= state_next == BMS_OFF;
      cfg_write_ok   <= state_next != BMS_INIT && state_next != BMS_SHUT
                        && state_next != BMS_OFF;
      state_code     <= 4'(state_next);
    end
  end

  // output drivers, normal state with brightness only
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      driver_en <= '0;
    else if (state_next == BMS_NORMAL && brightness_nz)
      driver_en <= string_used & ~(string_off_reg | sif.open_hit
                   | sif.short_hit);
    else
      driver_en <= '0;
  end

  // checks
  sequence s_en_drop;
    !en_pin && state_reg != BMS_SHUT && state_reg != BMS_OFF;
  endsequence
  sequence s_shut_entry;
    state_reg == BMS_SHUT ##1 discharge_en && !boost_en && !plsw_en;
  endsequence

  a_current_set_pin_force: assert property (@(posedge sys_clk) disable iff (!rst_n)
    current_set_pin_low |=> drive_current_code == 12'h3FF
      && !alert_n == ien_reg[`BMS_F_CURRENT_SET_PIN] && state_reg != BMS_RECOV)
    else $error("current set fault not handled");
  a_tsd_standby: assert property (@(posedge sys_clk) disable iff (!rst_n)
    en_pin && running && thermal_hot |=> state_reg == BMS_STANDBY
      && fault_flags[`BMS_F_TSD])
    else $error("thermal fault not to standby");
  a_standby_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == BMS_STANDBY && en_pin |=>
      (state_reg == BMS_SOFT) == !$past(thermal_hot))
    else $error("standby exit wrong");
  a_open_disable: assert property (@(posedge sys_clk) disable iff (!rst_n)
    |sif.open_hit && state_reg != BMS_INIT |=>
      (string_off & $past(sif.open_hit)) == $past(sif.open_hit))
    else $error("open string not disabled");
  a_gnd_recover: assert property (@(posedge sys_clk) disable iff (!rst_n)
    en_pin && gnd_hit && !thermal_hot && !all_off |=>
      state_reg == BMS_RECOV ##1 !plsw_en && !boost_en && driver_en == '0)
    else $error("ground short not recovered");
  a_bus_timeout: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_to_hit |=> bus_reset && fault_flags[`BMS_F_BUS] ##1 !bus_reset)
    else $error("bus timeout not handled");
  a_shutdown_seq: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_en_drop |=> s_shut_entry)
    else $error("enable drop not shut down");
  a_soft_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == BMS_SOFT && !tmr_done |=> state_reg != BMS_RAMP)
    else $error("soft start too short");
  a_recov_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == BMS_RECOV && !tmr_done |=> state_reg != BMS_STANDBY)
    else $error("recovery too short");
  a_latch_stay: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == BMS_LATCH && en_pin |=> state_reg == BMS_LATCH)
    else $error("latch left while enabled");
  a_clear_pair: assert property (@(posedge sys_clk) disable iff (!rst_n)
    flags_reg[`BMS_F_BUS] && !(clr_wr && clr_status[`BMS_F_BUS]
      && clr_bits[`BMS_F_BUS]) |=> fault_flags[`BMS_F_BUS])
    else $error("flag cleared without pair");
  a_drv_bright: assert property (@(posedge sys_clk) disable iff (!rst_n)
    driver_en != '0 |-> state_reg == BMS_NORMAL && $past(brightness_nz))
    else $error("drivers on outside normal");
endmodule // bms_seq_top

// ---- bms_defs.svh ----
// constants of the backlight mode sequencer
`ifndef BMS_DEFS_SVH
`define BMS_DEFS_SVH
`define BMS_CLK_HZ       50000000
`define BMS_CYC_PER_MS   (`BMS_CLK_HZ / 1000)
`define BMS_SHORT_MS     5
`define BMS_SOFT_MS      25
`define BMS_RAMP_MS      50
`define BMS_RECOV_MS     100
`define BMS_DISCH_MS     400
`define BMS_BUSTO_MS     500
`define BMS_SHORT_CYC    (`BMS_SHORT_MS * `BMS_CYC_PER_MS)
`define BMS_SOFT_CYC     (`BMS_SOFT_MS * `BMS_CYC_PER_MS)
`define BMS_RAMP_CYC     (`BMS_RAMP_MS * `BMS_CYC_PER_MS)
`define BMS_RECOV_CYC    (`BMS_RECOV_MS * `BMS_CYC_PER_MS)
`define BMS_DISCH_CYC    (`BMS_DISCH_MS * `BMS_CYC_PER_MS)
`define BMS_BUSTO_CYC    (`BMS_BUSTO_MS * `BMS_CYC_PER_MS)
`define BMS_TMR_W        25
`define BMS_NCH          4
`define BMS_NFLT         7
`define BMS_F_CURRENT_SET_PIN       0
`define BMS_F_TSD        1
`define BMS_F_OPEN       2
`define BMS_F_SHORT      3
`define BMS_F_GND        4
`define BMS_F_INV        5
`define BMS_F_BUS        6
`define BMS_CURRENT_SET_PIN_CODE    12'h3FF
`define BMS_IEN_RD_ON    2'h2
`define BMS_IEN_RD_OFF   2'h0
`define BMS_IEN_WR_OFF   2'h1
`define BMS_IEN_WR_ON    2'h3
`endif

// ---- bms_pkg.sv ----
// types of the backlight mode sequencer
`include "bms_defs.svh"
package bms_pkg;
  typedef enum logic [3:0] {
    BMS_INIT, BMS_STANDBY, BMS_SOFT, BMS_RAMP, BMS_NORMAL,
    BMS_RECOV, BMS_LATCH, BMS_SHUT, BMS_OFF
  } bms_state_e;
  typedef logic [`BMS_NCH-1:0]  bms_chmask_t;
  typedef logic [`BMS_NFLT-1:0] bms_flt_t;
endpackage

// ---- bms_str_if.sv ----
// string monitor signals between sequencer and monitor
`timescale 1ns/10ps
interface bms_str_if;
  logic               monitor_en;
  logic               boost_at_max;
  bms_pkg::bms_chmask_t active;
  bms_pkg::bms_chmask_t headroom_low;
  bms_pkg::bms_chmask_t headroom_high;
  bms_pkg::bms_chmask_t open_hit;
  bms_pkg::bms_chmask_t short_hit;
  modport seq (output monitor_en, boost_at_max, active, headroom_low,
               headroom_high, input open_hit, short_hit);
  modport mon (input monitor_en, boost_at_max, active, headroom_low,
               headroom_high, output open_hit, short_hit);
endinterface

// ---- bms_str_mon.sv ----
// per-string open and short detection
`timescale 1ns/10ps
`include "bms_defs.svh"
module bms_str_mon #(
  parameter int unsigned SHORT_CYC = `BMS_SHORT_CYC
)(
  input wire logic sys_clk,
  input wire logic rst_n,
  bms_str_if.mon   sif
);
  import bms_pkg::*;

  logic some_below;

  // an active string still under the short limit
  assign some_below = |(sif.active & ~sif.headroom_high);

  genvar ch;
  generate
    for (ch = 0; ch < `BMS_NCH; ch = ch + 1)
    begin : g_ch
      logic [`BMS_TMR_W-1:0] cnt_reg;
      logic                  over;
      assign over = sif.monitor_en & sif.active[ch]
                    & sif.headroom_high[ch] & some_below;
      // time the over-limit headroom
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
          cnt_reg <= '0;
        else if (!over)
          cnt_reg <= '0;
        else if (cnt_reg != `BMS_TMR_W'(SHORT_CYC))
          cnt_reg <= cnt_reg + `BMS_TMR_W'(1);
      end
      // short: one pulse per timed fault; open: high each cycle the open condition holds
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          sif.short_hit[ch] <= 1'b0;
          sif.open_hit[ch]  <= 1'b0;
        end
        else
        begin
          sif.short_hit[ch] <= over
            && cnt_reg == `BMS_TMR_W'(SHORT_CYC - 1);
          sif.open_hit[ch]  <= sif.monitor_en & sif.active[ch]
            & sif.headroom_low[ch] & sif.boost_at_max;
        end
      end
      a_short_time: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sif.short_hit[ch] |-> $past(cnt_reg) == `BMS_TMR_W'(SHORT_CYC - 1))
        else $error("short flagged before limit time");
    end
  endgenerate
endmodule // bms_str_mon

// ---- bms_host_model.sv ----
// host controller model: enable pin and status/alert-enable writes
`timescale 1ns/10ps
module bms_host_model
  import bms_pkg::*;
(
  input  wire logic sys_clk,
  output logic      en_pin,
  output logic      clr_wr,
  output bms_flt_t  clr_status,
  output bms_flt_t  clr_bits,
  output logic      ien_wr,
  output logic [13:0] ien_wdata
);
  // quiet writes, device enabled
  initial
  begin
    en_pin = 1'b1;
    {clr_wr, ien_wr, clr_status, clr_bits, ien_wdata} = '0;
  end
  // host drives the enable level; low is the only latch exit
  task automatic set_en(input logic v);
    @(posedge sys_clk);
    #1 en_pin = v;
  endtask
  // one-cycle clear write, status and clear bits side by side
  task automatic clear(input bms_flt_t st, input bms_flt_t cb);
    @(posedge sys_clk);
    #1 {clr_status, clr_bits, clr_wr} = {st, cb, 1'b1};
    @(posedge sys_clk);
    #1 {clr_status, clr_bits, clr_wr} = {~st, ~cb, 1'b0};
  endtask
  // one-cycle alert enable write, two bits per fault
  task automatic ien_write(input logic [13:0] d);
    @(posedge sys_clk);
    #1 {ien_wdata, ien_wr} = {d, 1'b1};
    @(posedge sys_clk);
    #1 {ien_wdata, ien_wr} = {~d, 1'b0};
  endtask
endmodule // bms_host_model

// ---- testbench.sv ----
// self-checking bench for the backlight mode sequencer
`timescale 1ns/10ps
module testbench;
  import bms_pkg::*;
  localparam int SOFT = 20, RAMP = 30, RECOV = 40;
  localparam int DISCH = 50, BUSTO = 60, SHORT = 10;
  typedef struct { string nm; int sel; logic [15:0] ex; } bms_note_s;
  logic sys_clk = 1'b0, rst_n = 1'b0, brightness_nz, ldo_ready;
  logic nvm_loaded, detect_done, current_set_pin_low, thermal_hot;
  logic boost_at_max, bus_busy, en_pin, clr_wr, ien_wr, alert_n;
  logic cfg_write_ok;
  bms_chmask_t string_used, headroom_low, headroom_high, gnd_low;
  bms_chmask_t unused_not_gnd, string_off, driver_en;
  logic [11:0] drive_current_cfg, drive_current_code;
  bms_flt_t clr_status, clr_bits, fault_flags;
  logic [13:0] ien_wdata, ien_rdata;
  logic [3:0] state_code;
  int errors = 0, comparisons = 0, meas;
  bms_note_s notes[$];
  bms_note_s nt;
  event look;
  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;
  bms_host_model host_i (.sys_clk, .en_pin, .clr_wr, .clr_status,
    .clr_bits, .ien_wr, .ien_wdata);
  bms_seq_top #(.SOFT_CYC(SOFT), .RAMP_CYC(RAMP), .RECOV_CYC(RECOV),
    .DISCH_CYC(DISCH), .BUSTO_CYC(BUSTO), .SHORT_CYC(SHORT)) bms_seq_top_i (
    .sys_clk, .rst_n, .en_pin, .brightness_nz, .ldo_ready, .nvm_loaded,
    .detect_done, .current_set_pin_low, .thermal_hot, .boost_at_max,
    .string_used, .headroom_low, .headroom_high, .gnd_low,
    .unused_not_gnd, .bus_busy, .drive_current_cfg, .clr_wr, .clr_status,
    .clr_bits, .ien_wr, .ien_wdata, .ien_rdata, .ldo_en(), .nvm_load_req(),
    .detect_req(), .plsw_en(), .plsw_soft(), .boost_en(),
    .boost_ilim_low(), .boost_flt_en(), .vin_flt_en(), .gnd_test_en(),
    .string_flt_en(), .driver_en, .string_off, .discharge_en(),
    .power_off(), .cfg_write_ok, .alert_n, .bus_reset(),
    .drive_current_code, .fault_flags, .state_code);
  // output picked by a note
  function automatic logic [15:0] seen(input int s);
    case (s)
      0: return {12'h0, state_code};
      1: return {15'h0, alert_n};
      2: return {9'h0, fault_flags};
      3: return {4'h0, drive_current_code};
      4: return {2'h0, ien_rdata};
      5: return {12'h0, string_off};
      7: return {12'h0, driver_en};
      8: return {15'h0, cfg_write_ok};
      default: return meas[15:0];
    endcase
  endfunction
  task automatic check(input string nm, input logic [15:0] sn, ex);
    comparisons++;
    if (sn !== ex)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, sn);
    end
  endtask
  task automatic note(input string nm, input int s, input logic [15:0] e);
    notes.push_back('{nm, s, e});
    ->look;
    // let the watcher drain before the stimulus moves on
    #0;
  endtask
  // watcher: oldest note against the output it names
  always @(look)
    while (notes.size() > 0)
    begin
      nt = notes.pop_front();
      check(nt.nm, seen(nt.sel), nt.ex);
    end
  task automatic wrap_up;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // bounded poll; meas holds edges waited
  task automatic wait_on(input int s, input logic [15:0] v);
    meas = 0;
    while (seen(s) !== v)
    begin
      @(posedge sys_clk);
      #1 meas++;
      if (meas > 3000)
      begin
        errors++;
        wrap_up();
      end
    end
  endtask
  initial
  begin
    void'($urandom(56));
    {ldo_ready, nvm_loaded, detect_done, current_set_pin_low} = '0;
    {thermal_hot, boost_at_max, bus_busy, brightness_nz} = '0;
    {headroom_low, headroom_high, gnd_low, unused_not_gnd} = '0;
    string_used = 4'h7; // channel 3 configured unused
    drive_current_cfg = 12'h123;
    tick(6);
    note("st_rst", 0, 16'h0);
    note("alert_rst", 1, 16'h1);
    note("code_rst", 3, 16'h3FF);
    note("ien_rst", 4, 16'h2AAA);
    rst_n = 1'b1;
    {ldo_ready, nvm_loaded, detect_done, brightness_nz} = 4'hF;
    wait_on(0, 16'h1);
    note("cfg_ok", 8, 16'h1);
    wait_on(0, 16'h2);
    wait_on(0, 16'h3);
    note("soft_len", 6, 16'(SOFT));
    wait_on(0, 16'h4);
    note("ramp_len", 6, 16'(RAMP));
    note("drv_on", 7, 16'h7);
    repeat (3)
    begin
      drive_current_cfg = 12'($urandom);
      tick(2);
      note("code_cfg", 3, {4'h0, drive_current_cfg});
    end
    current_set_pin_low = 1'b1;
    tick(2);
    note("code_low", 3, 16'h3FF);
    note("current_set_pin_flag", 2, 16'h1);
    note("current_set_pin_alert", 1, 16'h0);
    note("current_set_pin_norecov", 0, 16'h4);
    current_set_pin_low = 1'b0;
    host_i.clear(7'h01, 7'h00);
    tick(1);
    note("clr_half", 2, 16'h1);
    host_i.clear(7'h01, 7'h01);
    tick(1);
    note("clr_full", 2, 16'h0);
    note("clr_alert", 1, 16'h1);
    note("code_back", 3, {4'h0, drive_current_cfg});
    host_i.ien_write(14'h0001);
    tick(1);
    note("ien_off", 4, 16'h2AA8);
    current_set_pin_low = 1'b1;
    tick(3);
    note("masked", 1, 16'h1);
    current_set_pin_low = 1'b0;
    host_i.clear(7'h01, 7'h01);
    host_i.ien_write(14'h0003);
    tick(1);
    note("ien_on", 4, 16'h2AAA);
    unused_not_gnd = 4'h8;
    tick(2);
    note("inv_flag", 2, 16'h20);
    note("inv_alert", 1, 16'h0);
    note("inv_run", 0, 16'h4);
    unused_not_gnd = 4'h0;
    host_i.clear(7'h20, 7'h20);
    bus_busy = 1'b1;
    wait_on(2, 16'h40);
    meas = (meas >= BUSTO && meas <= BUSTO + 2) ? 1 : 0;
    note("bus_len", 6, 16'h1);
    note("bus_alert", 1, 16'h0);
    note("bus_run", 0, 16'h4);
    bus_busy = 1'b0;
    host_i.clear(7'h40, 7'h40);
    thermal_hot = 1'b1;
    wait_on(0, 16'h1);
    tick(5);
    note("hot_hold", 0, 16'h1);
    note("hot_flag", 2, 16'h2);
    thermal_hot = 1'b0;
    host_i.clear(7'h02, 7'h02);
    wait_on(0, 16'h4);
    brightness_nz = 1'b0;
    tick(2);
    note("drv_off", 7, 16'h0);
    gnd_low = 4'h2;
    wait_on(0, 16'h5);
    {gnd_low, brightness_nz} = 5'h01;
    wait_on(0, 16'h1);
    meas = (meas >= RECOV - 1 && meas <= RECOV + 1) ? 1 : 0;
    note("recov_len", 6, 16'h1);
    host_i.clear(7'h10, 7'h10);
    wait_on(0, 16'h4);
    headroom_high = 4'h1;
    wait_on(5, 16'h1);
    meas = (meas >= SHORT && meas <= SHORT + 3) ? 1 : 0;
    note("short_len", 6, 16'h1);
    note("short_flag", 2, 16'h8);
    {headroom_high, headroom_low, boost_at_max} = 9'h01D;
    wait_on(0, 16'h6);
    note("all_off", 5, 16'h7);
    tick(4);
    note("latch_hold", 0, 16'h6);
    host_i.set_en(1'b0);
    wait_on(0, 16'h7);
    wait_on(0, 16'h8);
    note("disch_len", 6, 16'(DISCH));
    note("cfg_off", 8, 16'h0);
    tick(2);
    wrap_up();
  end
endmodule // testbench
